// *** tb/cps_mem_model.sv ***
// Program and data memory model on the far side of the sequencer
`timescale 1ns/1ps
module cps_mem_model (
  // Clock
  input  wire logic        core_clk,
  // Program memory side
  input  wire logic [11:0] prog_addr,
  input  wire logic        prog_rd,
  output logic [15:0]      prog_data,
  // Data memory side
  input  wire logic [7:0]  dmem_addr,
  input  wire logic        dmem_rd,
  input  wire logic        dmem_wr,
  input  wire logic [7:0]  dmem_wdata,
  output logic [7:0]       dmem_rdata
);
  logic [15:0] rom [4096];
  logic [7:0]  ram [256];
  initial begin
    prog_data = 16'h0000;
    dmem_rdata = 8'h00;
    foreach (ram[i]) ram[i] = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read words follow the address while the strobe is high, then hold;
  // the core samples them at the edge that ends the strobe or later
  always @* begin
    if (prog_rd) prog_data = rom[prog_addr];
    if (dmem_rd) dmem_rdata = ram[dmem_addr];
  end
  // Writes land at the edge that ends the write pulse
  always @(posedge core_clk) begin
    if (dmem_wr) ram[dmem_addr] <= dmem_wdata;
  end
endmodule : cps_mem_model

// *** tb/cpu_program_sequencer_tb_top.sv ***
// Self-checking bench for the program sequencer core
`timescale 1ns/1ps
module cpu_program_sequencer_tb_top;
  logic        core_clk, rst_n, irq_req, irq_ack, prog_rd, dmem_rd, dmem_wr;
  logic        reg_wr, reg_rd;
  logic [11:0] prog_addr;
  logic [15:0] prog_data;
  logic [7:0]  dmem_addr, dmem_wdata, dmem_rdata, reg_wdata, reg_rdata, rd;
  logic [3:0]  reg_addr, cycle_phase_clocks;
  logic [11:0] fetch_log [$];
  int          failures, compares, n;
  // Program image: address and word; 1fff marks words that must be dropped
  logic [27:0] prog_tbl [20] = '{28'h002_5008, 28'h003_1fff, 28'h004_8000,
    28'h008_1005, 28'h009_1205, 28'h00a_5010, 28'h00b_1fff, 28'h010_6020,
    28'h011_9d40, 28'h012_1fff, 28'h013_5013, 28'h014_1fff, 28'h020_1037,
    28'h021_10d0, 28'h022_7000, 28'h023_1fff, 28'h030_5030, 28'h031_5030,
    28'h000_0000, 28'h040_6040};
  // Fetch order with dummy slots after jump, call, return and skip
  logic [11:0] exp_seq [19] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h008,
    12'h009, 12'h00a, 12'h00b, 12'h010, 12'h011, 12'h020, 12'h021, 12'h022,
    12'h023, 12'h011, 12'h012, 12'h013, 12'h014, 12'h013};

  cps_sequencer cps_sequencer_inst (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(1'b1), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
    .irq_req(irq_req), .irq_ack(irq_ack), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cycle_phase_clocks(cycle_phase_clocks));
  cps_mem_model cps_mem_model_inst (.core_clk(core_clk),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data),
    .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and monitors
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (prog_rd === 1'b1 && fetch_log.size() < 19) fetch_log.push_back(prog_addr);
  end
  always @(negedge core_clk) begin
    if (rst_n && !$onehot(cycle_phase_clocks)) begin
      failures++;
      $display("[ERR] %0t phases not one-hot", $time);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and bus tasks
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : check8
  task automatic check12(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t addr got %h exp %h", $time, got, exp);
    end
  endtask : check12
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // Bounded wait for a fetch of one address or for the acknowledge
  task automatic wait_for(input logic [11:0] a, input logic ack);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (!(ack ? irq_ack === 1'b1 : prog_rd === 1'b1 &&
                 prog_addr === a) && n < 80);
    check8({7'h00, n < 80}, 8'h01);
  endtask : wait_for
  task automatic wrap_up;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #20000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst_n = 1'b0;
    irq_req = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    compares = 0;
    foreach (cps_mem_model_inst.rom[i]) cps_mem_model_inst.rom[i] = 16'h0000;
    foreach (prog_tbl[i])
      cps_mem_model_inst.rom[prog_tbl[i][27:16]] = prog_tbl[i][15:0];
    #1;
    // Skip operand: ff increments to zero only if the read really lands
    cps_mem_model_inst.ram[8'h40] = 8'hff;
    @(posedge core_clk);
    #1;
    check8({4'h0, cycle_phase_clocks}, 8'h01);
    check12(prog_addr, cps_pkg::RESET_VECTOR);
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Reset values and an unmapped read, before the program touches them
    reg_read(cps_pkg::REG_STATUS, rd);
    check8(rd, cps_pkg::STATUS_RST);
    reg_read(cps_pkg::REG_CTRL, rd);
    check8(rd, cps_pkg::CTRL_RST);
    reg_read(cps_pkg::REG_ACC, rd);
    check8(rd, cps_pkg::ACC_RST);
    reg_read(4'hf, rd);
    check8(rd, 8'h00);
    // Straight run, jump, call, return and taken skip
    n = 0;
    while (fetch_log.size() < 19 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    foreach (exp_seq[i])
      check12(fetch_log.size() > i ? fetch_log[i] : 12'hfff, exp_seq[i]);
    // 0x37 + 0xd0 carries out; dropped words would leave ff
    reg_read(cps_pkg::REG_ACC, rd);
    check8(rd, 8'h07);
    reg_read(cps_pkg::REG_STATUS, rd);
    check8({7'h00, rd[cps_pkg::ST_C]}, 8'h01);
    // The skip wrote its incremented operand back
    check8(cps_mem_model_inst.ram[8'h40], 8'h00);
    // Low byte write jumps inside page zero
    reg_write(cps_pkg::REG_PCL, 8'h30);
    wait_for(12'h030, 1'b0);
    // Interrupt: acknowledge, vector, return and enable restored
    reg_write(cps_pkg::REG_CTRL, 8'h02);
    @(posedge core_clk);
    irq_req <= 1'b1;
    @(posedge core_clk);
    irq_req <= 1'b0;
    wait_for(12'h000, 1'b1);
    wait_for(cps_pkg::IRQ_VECTOR, 1'b0);
    wait_for(12'h030, 1'b0);
    reg_read(cps_pkg::REG_CTRL, rd);
    check8(rd, 8'h02);
    // Self-calling loop overflows the stack; a request then gets no ack
    reg_write(cps_pkg::REG_PCL, 8'h40);
    wait_for(12'h040, 1'b0);
    repeat (80) @(posedge core_clk);
    irq_req <= 1'b1;
    @(posedge core_clk);
    irq_req <= 1'b0;
    n = 0;
    repeat (40) @(posedge core_clk) n += int'(irq_ack === 1'b1);
    check8(n[7:0], 8'h00);
    wrap_up();
  end
endmodule : cpu_program_sequencer_tb_top

// *** verilog/cps_pkg.sv ***
// Constants and types shared by the program sequencer core
package cps_pkg;

  // Widths and stack depth
  localparam int             PC_W        = 12;
  localparam int             STACK_DEPTH = 8;
  localparam int             SP_W        = 4;
  localparam logic [3:0]     STACK_FULL  = 4'h8;
  localparam logic [3:0]     STACK_EMPTY = 4'h0;

  // Vectors
  localparam logic [11:0]    RESET_VECTOR = 12'h000;
  localparam logic [11:0]    IRQ_VECTOR   = 12'h004;

  // Core cycles per system clock edge when the slow oscillator is chosen
  localparam logic [7:0]     SLOW_DIV = 8'h20;

  // Register offsets on the plain register port
  localparam logic [3:0]     REG_PCL    = 4'h0;
  localparam logic [3:0]     REG_STATUS = 4'h1;
  localparam logic [3:0]     REG_CTRL   = 4'h2;
  localparam logic [3:0]     REG_ACC    = 4'h3;

  // Status and control fields, reset values
  localparam int             ST_C       = 0;
  localparam int             ST_AC      = 1;
  localparam int             ST_Z       = 2;
  localparam int             ST_OV      = 3;
  localparam int             CTRL_SLOW  = 0;
  localparam int             CTRL_IE    = 1;
  localparam logic [7:0]     STATUS_RST = 8'h00;
  localparam logic [7:0]     CTRL_RST   = 8'h00;
  localparam logic [7:0]     ACC_RST    = 8'h00;

  // Instruction word fields
  localparam int             OP_MSB = 15;
  localparam int             OP_LSB = 12;
  localparam int             FN_MSB = 11;
  localparam int             FN_LSB = 8;
  localparam logic [15:0]    INSTR_RST = 16'h0000;

  typedef enum logic [3:0] {
    OP_NOP, OP_ALU_IMM, OP_ALU_RD, OP_ALU_WR, OP_EXT_WR, OP_JMP, OP_CALL,
    OP_RET, OP_INTERRUPT_RETURN_OP, OP_SKIP, OP_PCL_WR, OP_PCL_RD
  } cps_op_e;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
    ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_PASS
  } cps_alu_e;

  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cps_phase_e;

endpackage : cps_pkg

// *** verilog/cps_sequencer.sv ***
// Program sequencer: phases, fetch pipeline, PC, return stack and ALU
//
// Behaviour
// - System clock edges come from the fast or the divided slow oscillator.
// - Four phases per instruction cycle, one-hot and non-overlapping.
// - PC advances and a fetch starts at the first phase.
// - Fetch overlaps execution; extended instructions take two cycles.
// - PC-changing instructions add one cycle that fetches the target.
// - PC increments by one unless control goes elsewhere.
// - Jump, call, interrupt and reset load their target directly.
// - A taken skip discards the prefetched word and runs a dummy cycle.
// - PC is 12 bits; only its low byte is software visible.
// - Writing the low byte jumps inside the current page with a dummy cycle.
// - Return stack holds PC values only and is hidden from software.
// - Call and interrupt push the PC; returns pop it back.
// - Reset sets the stack pointer to the top position.
// - Interrupts wait, flag kept, while the stack is full.
// - A call on a full stack still pushes and loses the oldest entry.
// - An 8-bit ALU moves data through the accumulator to the target.
// - ALU operations except skip tests update carry, borrow and other status flags.
// - ALU covers add, subtract, adjust, logic, rotate, step and skip tests.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module cps_sequencer (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Program memory
  output logic [11:0]      prog_addr,
  output logic             prog_rd,
  input  wire logic [15:0] prog_data,
  // Data memory
  output logic [7:0]       dmem_addr,
  output logic             dmem_rd,
  output logic             dmem_wr,
  output logic [7:0]       dmem_wdata,
  input  wire logic [7:0]  dmem_rdata,
  // Interrupt request and acknowledge
  input  wire logic        irq_req,
  output logic             irq_ack,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Phase clocks
  output logic [3:0]       cycle_phase_clocks
);

  logic                    rst_meta_n;
  logic                    rst_sync_n;
  logic [7:0]              div_cnt;
  logic                    tick;
  cps_pkg::cps_phase_e     ph;
  logic                    t1, t2, t3, t4;
  logic [11:0]             pc;
  logic [15:0]             ir;
  logic                    ir_valid;
  logic                    ext_second;
  logic                    flush;
  logic                    hold;
  logic [15:0]             fetch_word;
  logic [7:0]              mem_q;
  logic [7:0]              acc;
  logic [7:0]              status;
  logic [7:0]              ctrl;
  logic                    irq_pend;
  logic                    pcl_pend;
  logic [7:0]              pcl_val;
  logic [11:0]             stk [cps_pkg::STACK_DEPTH];
  logic [3:0]              sp_cnt;
  logic                    stk_full;
  cps_pkg::cps_op_e        op;
  logic [7:0]              opd;
  logic [15:0]             alu_out;
  logic [11:0]             ret_addr;
  logic [11:0]             next_pc;
  logic                    redirect, push, pop, take_irq, pcl_take;
  logic                    acc_we, st_we, mem_we, stall, ie_set, uses_mem;

  // ALU: {new status, result}; unary ops work on the second operand, except DAA, which adjusts the first
  function automatic logic [15:0] alu_calc(input logic [3:0] fn,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] st);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] adj;
    logic [7:0] f;
    logic       ci;
    s   = 9'h000;
    h   = 5'h00;
    adj = 8'h00;
    f   = st;
    ci  = 1'b0;
    r   = b;
    unique case (cps_pkg::cps_alu_e'(fn))
      cps_pkg::ALU_ADD, cps_pkg::ALU_ADC: begin
        ci = (fn == cps_pkg::ALU_ADC) & st[cps_pkg::ST_C];
        s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        r  = s[7:0];
        f[cps_pkg::ST_C]  = s[8];
        f[cps_pkg::ST_AC] = h[4];
        f[cps_pkg::ST_OV] = (a[7] == b[7]) && (r[7] != a[7]);
      end
      cps_pkg::ALU_SUB, cps_pkg::ALU_SBC: begin
        // Carry set means no borrow
        ci = (fn == cps_pkg::ALU_SBC) & ~st[cps_pkg::ST_C];
        s  = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        h  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        r  = s[7:0];
        f[cps_pkg::ST_C]  = ~s[8];
        f[cps_pkg::ST_AC] = ~h[4];
        f[cps_pkg::ST_OV] = (a[7] != b[7]) && (r[7] != a[7]);
      end
      cps_pkg::ALU_DAA: begin
        adj[3:0] = (a[3:0] > 4'h9 || st[cps_pkg::ST_AC]) ? 4'h6 : 4'h0;
        adj[7:4] = (a[7:4] > 4'h9 || st[cps_pkg::ST_C]) ? 4'h6 : 4'h0;
        s = {1'b0, a} + {1'b0, adj};
        r = s[7:0];
        f[cps_pkg::ST_C] = st[cps_pkg::ST_C] | s[8];
      end
      cps_pkg::ALU_AND:  r = a & b;
      cps_pkg::ALU_OR:   r = a | b;
      cps_pkg::ALU_XOR:  r = a ^ b;
      cps_pkg::ALU_CPL:  r = ~b;
      cps_pkg::ALU_RR:   r = {b[0], b[7:1]};
      cps_pkg::ALU_RL:   r = {b[6:0], b[7]};
      cps_pkg::ALU_RRC: begin
        r = {st[cps_pkg::ST_C], b[7:1]};
        f[cps_pkg::ST_C] = b[0];
      end
      cps_pkg::ALU_RLC: begin
        r = {b[6:0], st[cps_pkg::ST_C]};
        f[cps_pkg::ST_C] = b[7];
      end
      cps_pkg::ALU_INC:  r = b + 8'h01;
      cps_pkg::ALU_DEC:  r = b - 8'h01;
      cps_pkg::ALU_PASS: r = b;
    endcase
    f[cps_pkg::ST_Z] = (r == 8'h00);
    return {f, r};
  endfunction : alu_calc

  //////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Slow oscillator modelled as a divided enable of the core clock
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt <= 8'h00;
    end else if (clk_en) begin
      if (!ctrl[cps_pkg::CTRL_SLOW] || div_cnt == cps_pkg::SLOW_DIV - 8'h01)
        div_cnt <= 8'h00;
      else
        div_cnt <= div_cnt + 8'h01;
    end
  end

  // Gated by the synced reset so no phase strobe shows while reset is held
  assign tick = rst_sync_n && clk_en
             && (!ctrl[cps_pkg::CTRL_SLOW] || div_cnt == 8'h00);
  assign t1   = tick && ph == cps_pkg::PH_T1;
  assign t2   = tick && ph == cps_pkg::PH_T2;
  assign t3   = tick && ph == cps_pkg::PH_T3;
  assign t4   = tick && ph == cps_pkg::PH_T4;

  // Phase sequencer, one phase per system clock edge
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ph                 <= cps_pkg::PH_T1;
      cycle_phase_clocks <= 4'h1;
    end else if (tick) begin
      unique case (ph)
        cps_pkg::PH_T1: ph <= cps_pkg::PH_T2;
        cps_pkg::PH_T2: ph <= cps_pkg::PH_T3;
        cps_pkg::PH_T3: ph <= cps_pkg::PH_T4;
        cps_pkg::PH_T4: ph <= cps_pkg::PH_T1;
      endcase
      cycle_phase_clocks <= {cycle_phase_clocks[2:0], cycle_phase_clocks[3]};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Execute decisions, acted on at the fourth phase
  assign op       = cps_pkg::cps_op_e'(ir[cps_pkg::OP_MSB:cps_pkg::OP_LSB]);
  assign opd      = ir[7:0];
  assign stk_full = (sp_cnt == cps_pkg::STACK_FULL);
  // Prefetched word sits at pc-1; that is where control must come back
  assign ret_addr = pc - 12'h001;
  assign alu_out  = alu_calc(ir[cps_pkg::FN_MSB:cps_pkg::FN_LSB], acc,
                             (op == cps_pkg::OP_ALU_IMM) ? opd : mem_q,
                             status);

  always_comb begin
    next_pc  = pc;
    redirect = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    take_irq = 1'b0;
    pcl_take = 1'b0;
    acc_we   = 1'b0;
    st_we    = 1'b0;
    mem_we   = 1'b0;
    stall    = 1'b0;
    ie_set   = 1'b0;
    uses_mem = 1'b0;
    if (ir_valid) begin
      case (op)
        cps_pkg::OP_ALU_IMM: begin
          acc_we = 1'b1;
          st_we  = 1'b1;
        end
        cps_pkg::OP_ALU_RD: begin
          uses_mem = 1'b1;
          acc_we   = 1'b1;
          st_we    = 1'b1;
        end
        cps_pkg::OP_ALU_WR: begin
          uses_mem = 1'b1;
          mem_we   = 1'b1;
          st_we    = 1'b1;
        end
        cps_pkg::OP_EXT_WR: begin
          uses_mem = 1'b1;
          stall    = !ext_second;
          mem_we   = ext_second;
          st_we    = ext_second;
        end
        cps_pkg::OP_JMP: begin
          redirect = 1'b1;
          next_pc  = ir[11:0];
        end
        cps_pkg::OP_CALL: begin
          redirect = 1'b1;
          push     = 1'b1;
          next_pc  = ir[11:0];
        end
        cps_pkg::OP_RET, cps_pkg::OP_INTERRUPT_RETURN_OP: begin
          redirect = 1'b1;
          pop      = 1'b1;
          ie_set   = (op == cps_pkg::OP_INTERRUPT_RETURN_OP);
          next_pc  = stk[0];
        end
        cps_pkg::OP_SKIP: begin
          uses_mem = 1'b1;
          mem_we   = (ir[cps_pkg::FN_MSB:cps_pkg::FN_LSB] != cps_pkg::ALU_PASS);
          // Taken skip refetches from pc, dropping the prefetched word
          redirect = (alu_out[7:0] == 8'h00);
        end
        cps_pkg::OP_PCL_WR: begin
          redirect = 1'b1;
          next_pc  = {pc[11:8], opd};
        end
        cps_pkg::OP_PCL_RD: acc_we = 1'b1;
        default: ;
      endcase
    end
    if (!redirect && !stall && pcl_pend) begin
      redirect = 1'b1;
      pcl_take = 1'b1;
      next_pc  = {pc[11:8], pcl_val};
    end else if (!redirect && !stall && irq_pend && ctrl[cps_pkg::CTRL_IE]
                 && !stk_full) begin
      redirect = 1'b1;
      push     = 1'b1;
      take_irq = 1'b1;
      next_pc  = cps_pkg::IRQ_VECTOR;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Program counter: step at first phase, reload at fourth
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pc <= cps_pkg::RESET_VECTOR;
    end else if (t1 && !hold) begin
      pc <= pc + 12'h001;
    end else if (t4 && redirect) begin
      pc <= next_pc;
    end
  end

  // Fetch port; the word lands in fetch_word one phase later
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prog_addr  <= cps_pkg::RESET_VECTOR;
      prog_rd    <= 1'b0;
      fetch_word <= cps_pkg::INSTR_RST;
    end else if (clk_en) begin
      prog_rd <= t1 && !hold;
      if (t1 && !hold)
        prog_addr <= pc;
      if (t2 && !hold)
        fetch_word <= prog_data;
    end
  end

  // Instruction register; a flushed slot executes as a dummy cycle
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ir         <= cps_pkg::INSTR_RST;
      ir_valid   <= 1'b0;
      ext_second <= 1'b0;
      flush      <= 1'b1;
      hold       <= 1'b0;
    end else if (t1) begin
      if (hold) begin
        ext_second <= 1'b1;
      end else begin
        ir         <= fetch_word;
        ir_valid   <= !flush;
        ext_second <= 1'b0;
      end
    end else if (t4) begin
      flush <= redirect;
      hold  <= stall;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Data memory: address at second phase, sample at third, write at fourth
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dmem_addr  <= 8'h00;
      dmem_rd    <= 1'b0;
      dmem_wr    <= 1'b0;
      dmem_wdata <= 8'h00;
      mem_q      <= 8'h00;
    end else if (clk_en) begin
      dmem_rd <= t2 && uses_mem;
      dmem_wr <= t4 && mem_we;
      if (t2 && uses_mem)
        dmem_addr <= opd;
      if (t3)
        mem_q <= dmem_rdata;
      if (t4 && mem_we)
        dmem_wdata <= alu_out[7:0];
    end
  end

  // Accumulator and status; core updates win over register writes
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc    <= cps_pkg::ACC_RST;
      status <= cps_pkg::STATUS_RST;
    end else if (clk_en) begin
      if (t4 && acc_we)
        acc <= (op == cps_pkg::OP_PCL_RD) ? pc[7:0] : alu_out[7:0];
      else if (reg_wr && reg_addr == cps_pkg::REG_ACC)
        acc <= reg_wdata;
      if (t4 && st_we)
        status <= alu_out[15:8];
      else if (reg_wr && reg_addr == cps_pkg::REG_STATUS)
        status <= reg_wdata;
    end
  end

  // Control, pending interrupt and pending low-byte write
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl     <= cps_pkg::CTRL_RST;
      irq_pend <= 1'b0;
      irq_ack  <= 1'b0;
      pcl_pend <= 1'b0;
      pcl_val  <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == cps_pkg::REG_CTRL)
        ctrl <= reg_wdata;
      if (t4 && take_irq)
        ctrl[cps_pkg::CTRL_IE] <= 1'b0;
      else if (t4 && ie_set)
        ctrl[cps_pkg::CTRL_IE] <= 1'b1;
      // New request in the ack cycle is kept
      irq_pend <= irq_req || (irq_pend && !(t4 && take_irq));
      irq_ack  <= t4 && take_irq;
      // A fresh write in the consume cycle stays pending
      if (reg_wr && reg_addr == cps_pkg::REG_PCL) begin
        pcl_pend <= 1'b1;
        pcl_val  <= reg_wdata;
      end else if (t4 && pcl_take) begin
        pcl_pend <= 1'b0;
      end
    end
  end

  // Read port; the stack and its pointer have no address
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        case (reg_addr)
          cps_pkg::REG_PCL:    reg_rdata <= pc[7:0];
          cps_pkg::REG_STATUS: reg_rdata <= status;
          cps_pkg::REG_CTRL:   reg_rdata <= ctrl;
          cps_pkg::REG_ACC:    reg_rdata <= acc;
          default:             reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Return stack as a shift array: a push on a full stack drops the oldest
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sp_cnt <= cps_pkg::STACK_EMPTY;
    end else if (t4 && push && !stk_full) begin
      sp_cnt <= sp_cnt + 4'h1;
    end else if (t4 && pop && sp_cnt != cps_pkg::STACK_EMPTY) begin
      sp_cnt <= sp_cnt - 4'h1;
    end
  end

  for (genvar i = 0; i < cps_pkg::STACK_DEPTH; i++) begin : g_stk
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        stk[i] <= cps_pkg::RESET_VECTOR;
      end else if (t4 && push) begin
        if (i == 0)
          stk[i] <= ret_addr;
        else
          stk[i] <= stk[(i == 0) ? 0 : i - 1];
      end else if (t4 && pop) begin
        // Clamped index keeps the unused end entry in range
        if (i < cps_pkg::STACK_DEPTH - 1)
          stk[i] <= stk[(i < cps_pkg::STACK_DEPTH - 1) ? i + 1 : i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  phase_onehot_a: assert property ($onehot(cycle_phase_clocks))
    else $error("phase clocks not one-hot");
  phase_rotate_a: assert property (tick |=> cycle_phase_clocks ==
      {$past(cycle_phase_clocks[2:0]), $past(cycle_phase_clocks[3])})
    else $error("phase did not advance");
  pc_step_a: assert property ((t1 && !hold) |=> pc == $past(pc) + 12'h001)
    else $error("pc did not step at first phase");
  fetch_addr_a: assert property ($rose(prog_rd) |-> prog_addr == pc - 12'h001)
    else $error("fetch address not the stepped pc");
  redirect_load_a: assert property ((t4 && redirect) |=>
      pc == $past(next_pc) && flush)
    else $error("redirect did not load pc or mark a flush");
  dummy_slot_a: assert property ((t1 && flush && !hold) |=> !ir_valid)
    else $error("flushed slot was executed");
  full_push_a: assert property ((t4 && push && stk_full) |=>
      stk_full && stk[0] == $past(ret_addr))
    else $error("full push lost the newest entry");
  irq_hold_a: assert property ((irq_pend && stk_full) |-> !take_irq)
    else $error("interrupt acknowledged on full stack");
  pcl_page_a: assert property ((t4 && ir_valid && op == cps_pkg::OP_PCL_WR)
      |=> pc == {$past(pc[11:8]), $past(opd)})
    else $error("low byte jump left the page");
  ack_cause_a: assert property (irq_ack |-> $past(irq_pend) && !$past(stk_full))
    else $error("acknowledge without pending request");

  call_c: cover property (t4 && ir_valid && op == cps_pkg::OP_CALL);
  skip_c: cover property (t4 && ir_valid && op == cps_pkg::OP_SKIP && redirect);
  irq_c:  cover property (irq_ack);
  ext_c:  cover property (t4 && ext_second && mem_we);

endmodule : cps_sequencer
